// ---- hw/loop_alarm_regs.vh ----
`ifndef LOOP_ALARM_REGS_VH
`define LOOP_ALARM_REGS_VH
// Register byte offsets
`define LA_OFS_IRQ_EN      5'h00
`define LA_OFS_ALARM_STS   5'h04
`define LA_OFS_IRQ_STS     5'h08
`define LA_OFS_CTRL        5'h0C
`define LA_ADDR_W          5
// Field positions
`define LA_BIT_GLOBAL_EN   7
`define LA_BIT_LOOP        3
`define LA_BIT_AIS         2
`define LA_BIT_LOS         1
`define LA_BIT_PRBS        0
`define LA_BIT_SEL_HI      1
`define LA_BIT_SEL_LO      0
// Detection modes
`define LA_MODE_OFF        2'h0
`define LA_MODE_AUTO       2'h3
// Reset values
`define LA_RST_BYTE        8'h00
`define LA_RST_MODE        2'h0
// Persistence window
`define LA_PERSIST_S       5
`define LA_CLK_HZ          250000000
`define LA_CNT_W           31
// Bus responses
`define LA_RESP_OKAY       2'h0
`define LA_RESP_SLVERR     2'h2
`endif

// ---- hw/loop_code_and_rx_alarm_status.v ----
`include "loop_alarm_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module loop_code_and_rx_alarm_status #(
  parameter [`LA_CNT_W-1:0] PERSIST_CYCLES = `LA_PERSIST_S * `LA_CLK_HZ
) (
  // Clock and reset
  input  wire                  ref_clk,
  input  wire                  reset_n,
  // Detector inputs, asynchronous
  input  wire                  loop_up_det,
  input  wire                  loop_down_det,
  input  wire                  all_ones_det,
  input  wire                  signal_lost_det,
  input  wire                  prbs_sync_det,
  // Line control and interrupt
  output reg                   remote_loopback_reg,
  output reg                   irq_reg,
  // AXI4-Lite write address
  input  wire [`LA_ADDR_W-1:0] s_axi_awaddr,
  input  wire                  s_axi_awvalid,
  output reg                   s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output reg                   s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,
  // AXI4-Lite read address
  input  wire [`LA_ADDR_W-1:0] s_axi_araddr,
  input  wire                  s_axi_arvalid,
  output reg                   s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; first stage feeds only the second
  wire [4:0]            det_raw  = {loop_up_det, loop_down_det, all_ones_det,
                                    signal_lost_det, prbs_sync_det};
  wire [4:0]            det_sync;
  genvar                gi;

  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_sync
      reg                 sync1_reg;
      reg                 sync2_reg;

      always @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          sync1_reg <= 1'b0;
          sync2_reg <= 1'b0;
        end
        else
        begin
          sync1_reg <= det_raw[gi];
          sync2_reg <= sync1_reg;
        end
      end

      assign det_sync[gi] = sync2_reg;
    end
  endgenerate

  wire                  up_s    = det_sync[4];
  wire                  down_s  = det_sync[3];
  wire                  ais_s   = det_sync[2];
  wire                  los_s   = det_sync[1];
  wire                  prbs_s  = det_sync[0];

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  reg  [7:0]            irq_en_reg;
  reg  [7:0]            irq_en_next;
  reg  [3:0]            irq_sts_reg;
  reg  [1:0]            mode_reg;
  reg  [1:0]            prev_mode_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Loop-code detection
  reg                   loop_flag_reg;
  reg                   loop_flag_next;
  reg                   loopback_next;
  reg  [`LA_CNT_W-1:0]  persist_cnt_reg;
  reg  [`LA_CNT_W-1:0]  persist_cnt_next;
  reg                   restart;
  reg                   down_hit;

  wire                  auto_mode  = (mode_reg == `LA_MODE_AUTO);
  wire                  off_mode   = (mode_reg == `LA_MODE_OFF);
  wire                  enter_auto = auto_mode && (prev_mode_reg != `LA_MODE_AUTO);
  // Manual mode accepts either code; auto seeks one code per phase
  wire                  present    = auto_mode ? (remote_loopback_reg ? down_s : up_s)
                                               : (up_s | down_s);
  // Saturated count means present longer than the window
  wire                  persisted  = present && (persist_cnt_reg == PERSIST_CYCLES);

  always @*
  begin
    loop_flag_next = loop_flag_reg;
    loopback_next  = remote_loopback_reg;
    restart        = 1'b0;
    down_hit       = 1'b0;
    if (off_mode)
    begin
      loop_flag_next = 1'b0;
      loopback_next  = 1'b0;
      restart        = 1'b1;
    end
    else if (enter_auto)
    begin
      loop_flag_next = 1'b0;
      loopback_next  = 1'b0;
      restart        = 1'b1;
    end
    else if (auto_mode)
    begin
      if (!remote_loopback_reg && persisted)
      begin
        loop_flag_next = 1'b1;
        loopback_next  = 1'b1;
        restart        = 1'b1;
      end
      else if (remote_loopback_reg && persisted)
      begin
        loop_flag_next = 1'b0;
        loopback_next  = 1'b0;
        restart        = 1'b1;
        down_hit       = 1'b1;
      end
      else
        loop_flag_next = remote_loopback_reg;
    end
    else
    begin
      loopback_next = 1'b0;
      if (!present)
        loop_flag_next = 1'b0;
      else if (persisted)
      begin
        loop_flag_next = 1'b1;
        down_hit       = down_s && !up_s;
      end
    end
  end

  always @*
  begin
    if (restart || !present)
      persist_cnt_next = {`LA_CNT_W{1'b0}};
    else if (persist_cnt_reg != PERSIST_CYCLES)
      persist_cnt_next = persist_cnt_reg + {{(`LA_CNT_W-1){1'b0}}, 1'b1};
    else
      persist_cnt_next = persist_cnt_reg;
  end

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      loop_flag_reg       <= 1'b0;
      remote_loopback_reg <= 1'b0;
      persist_cnt_reg     <= {`LA_CNT_W{1'b0}};
      prev_mode_reg       <= `LA_RST_MODE;
    end
    else
    begin
      loop_flag_reg       <= loop_flag_next;
      remote_loopback_reg <= loopback_next;
      persist_cnt_reg     <= persist_cnt_next;
      prev_mode_reg       <= mode_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live status and change tracking
  wire [3:0]            live_sts = {loop_flag_reg, ais_s, los_s, prbs_s};
  reg  [3:0]            prev_sts_reg;
  wire [3:0]            changed  = live_sts ^ prev_sts_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; write address and data held until both arrive
  reg  [`LA_ADDR_W-1:0] waddr_reg;
  reg                   waddr_ok_reg;
  reg  [31:0]           wdata_reg;
  reg  [3:0]            wstrb_reg;
  reg                   wdata_ok_reg;

  wire                  aw_take  = s_axi_awvalid && s_axi_awready;
  wire                  w_take   = s_axi_wvalid && s_axi_wready;
  wire                  ar_take  = s_axi_arvalid && s_axi_arready;
  wire                  do_write = waddr_ok_reg && wdata_ok_reg && !s_axi_bvalid;
  wire                  wr_lane0 = do_write && wstrb_reg[0];
  wire                  wr_map   = (waddr_reg == `LA_OFS_IRQ_EN) ||
                                   (waddr_reg == `LA_OFS_ALARM_STS) ||
                                   (waddr_reg == `LA_OFS_IRQ_STS) ||
                                   (waddr_reg == `LA_OFS_CTRL);
  wire                  rd_map   = (s_axi_araddr == `LA_OFS_IRQ_EN) ||
                                   (s_axi_araddr == `LA_OFS_ALARM_STS) ||
                                   (s_axi_araddr == `LA_OFS_IRQ_STS) ||
                                   (s_axi_araddr == `LA_OFS_CTRL);
  wire [3:0]            rd_clr   = (ar_take && s_axi_araddr == `LA_OFS_IRQ_STS) ? irq_sts_reg
                                                                                : 4'h0;
  wire [3:0]            w1c_clr  = (wr_lane0 && waddr_reg == `LA_OFS_IRQ_STS) ? wdata_reg[3:0]
                                                                              : 4'h0;
  reg  [31:0]           rd_word;

  always @*
  begin
    case (s_axi_araddr)
      `LA_OFS_IRQ_EN:    rd_word = {24'h000000, irq_en_reg};
      `LA_OFS_ALARM_STS: rd_word = {28'h0000000, live_sts};
      `LA_OFS_IRQ_STS:   rd_word = {28'h0000000, irq_sts_reg};
      `LA_OFS_CTRL:      rd_word = {30'h0000000, mode_reg};
      default:           rd_word = 32'h00000000;
    endcase
  end

  always @*
  begin
    irq_en_next = irq_en_reg;
    if (wr_lane0 && waddr_reg == `LA_OFS_IRQ_EN)
      irq_en_next = {wdata_reg[`LA_BIT_GLOBAL_EN], 3'h0, wdata_reg[3:0]};
    // Hardware clear beats a simultaneous software write
    if (down_hit)
      irq_en_next[`LA_BIT_LOOP] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write address and data capture; either may arrive first
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      waddr_reg     <= {`LA_ADDR_W{1'b0}};
      waddr_ok_reg  <= 1'b0;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      wdata_ok_reg  <= 1'b0;
    end
    else
    begin
      // Ready stays low until the pending write has been answered
      s_axi_awready <= !waddr_ok_reg && !aw_take && !s_axi_bvalid;
      s_axi_wready  <= !wdata_ok_reg && !w_take && !s_axi_bvalid;
      if (aw_take)
      begin
        waddr_reg    <= s_axi_awaddr;
        waddr_ok_reg <= 1'b1;
      end
      else if (do_write)
        waddr_ok_reg <= 1'b0;
      if (w_take)
      begin
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        wdata_ok_reg <= 1'b1;
      end
      else if (do_write)
        wdata_ok_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write response
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LA_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      // Unmapped offsets are answered, never left hanging
      s_axi_bresp  <= wr_map ? `LA_RESP_OKAY : `LA_RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `LA_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take)
      begin
        // Read data is the pre-clear value of the change bits
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_map ? `LA_RESP_OKAY : `LA_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode
  wire                  wr_ctrl  = wr_lane0 && (waddr_reg == `LA_OFS_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests; each source gated by its own enable
  wire                  loop_req = irq_sts_reg[`LA_BIT_LOOP] &&
                                   irq_en_next[`LA_BIT_LOOP];
  wire                  ais_req  = irq_sts_reg[`LA_BIT_AIS] &&
                                   irq_en_next[`LA_BIT_AIS];
  wire                  los_req  = irq_sts_reg[`LA_BIT_LOS] &&
                                   irq_en_next[`LA_BIT_LOS];
  wire                  prbs_req = irq_sts_reg[`LA_BIT_PRBS] &&
                                   irq_en_next[`LA_BIT_PRBS];
  wire                  irq_any  = loop_req || ais_req || los_req || prbs_req;

  ////////////////////////////////////////////////////////////////////////////
  // Control, change bits and interrupt line
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_en_reg   <= `LA_RST_BYTE;
      mode_reg     <= `LA_RST_MODE;
      irq_sts_reg  <= 4'h0;
      prev_sts_reg <= 4'h0;
      irq_reg      <= 1'b0;
    end
    else
    begin
      irq_en_reg <= irq_en_next;
      if (wr_ctrl)
        mode_reg <= {wdata_reg[`LA_BIT_SEL_HI], wdata_reg[`LA_BIT_SEL_LO]};
      prev_sts_reg <= live_sts;
      // A change in the clearing cycle survives the clear
      irq_sts_reg  <= (irq_sts_reg & ~(rd_clr | w1c_clr)) | changed;
      // Global enable masks every source
      irq_reg      <= irq_en_next[`LA_BIT_GLOBAL_EN] && irq_any;
    end
  end

endmodule // loop_code_and_rx_alarm_status

`default_nettype wire

// ---- testbench/loop_code_props.sv ----
`include "loop_alarm_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module loop_code_props #(
  parameter [`LA_CNT_W-1:0] PERSIST_CYCLES = 20
) (
  // Clock, reset, line side
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        loop_up_det,
  input wire logic        loop_down_det,
  input wire logic        remote_loopback_reg,
  input wire logic        irq_reg,
  // Register bus
  input wire logic [4:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  // Slack covers the two-flop synchroniser ahead of the counter
  localparam int PL = PERSIST_CYCLES - 4;
  int   up_cnt;
  int   dn_cnt;
  logic ar_bad;
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      up_cnt <= 0;
      dn_cnt <= 0;
      ar_bad <= 1'b0;
    end
    else
    begin
      up_cnt <= !loop_up_det ? 0 : (up_cnt < 1000) ? up_cnt + 1 : up_cnt;
      dn_cnt <= !loop_down_det ? 0 : (dn_cnt < 1000) ? dn_cnt + 1 : dn_cnt;
      if (s_axi_arvalid && s_axi_arready)
        ar_bad <= (s_axi_araddr > 5'h0C) || (s_axi_araddr[1:0] != 2'h0);
    end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_lb_rise;
    $rose(remote_loopback_reg) |-> $past(up_cnt, 2) >= PL;
  endproperty
  a_lb_rise: assert property (p_lb_rise) else $error("loopback set too soon");
  // A control write may also drop loopback by leaving auto mode
  property p_lb_fall;
    $fell(remote_loopback_reg) |->
      $past(dn_cnt, 2) >= PL || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_lb_fall: assert property (p_lb_fall) else $error("loopback dropped early");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_ar_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("arready during read");
  property p_w_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_busy: assert property (p_w_busy) else $error("write ready too early");
  property p_rresp;
    $rose(s_axi_rvalid) |-> s_axi_rresp == (ar_bad ? `LA_RESP_SLVERR : `LA_RESP_OKAY);
  endproperty
  a_rresp: assert property (p_rresp) else $error("wrong read response");
  property p_rd_hi;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  c_lb_on: cover property ($rose(remote_loopback_reg));
  c_lb_off: cover property ($fell(remote_loopback_reg));
  c_irq: cover property ($rose(irq_reg));
endmodule // loop_code_props
bind loop_code_and_rx_alarm_status loop_code_props #(.PERSIST_CYCLES(PERSIST_CYCLES)) u_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .loop_up_det(loop_up_det),
  .loop_down_det(loop_down_det), .remote_loopback_reg(remote_loopback_reg),
  .irq_reg(irq_reg), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
`default_nettype wire

// ---- testbench/remote_net_end.sv ----
`timescale 1ns/1ns
`default_nettype none
module remote_net_end (
  // Clock
  input  wire logic ref_clk,
  // Detector levels seen on the line
  output var logic  loop_up_det,
  output var logic  loop_down_det,
  output var logic  all_ones_det,
  output var logic  signal_lost_det,
  output var logic  prbs_sync_det
);
  initial
  begin
    {loop_up_det, loop_down_det} = 2'h0;
    {all_ones_det, signal_lost_det, prbs_sync_det} = 3'h0;
  end
  // Levels move just after an edge, as from the recovered clock
  task codes(input logic u, input logic d);
    @(posedge ref_clk);
    loop_up_det <= u;
    loop_down_det <= d;
  endtask
  task alarms(input logic [2:0] v);
    @(posedge ref_clk);
    {all_ones_det, signal_lost_det, prbs_sync_det} <= v;
  endtask
endmodule // remote_net_end
`default_nettype wire

// ---- testbench/tb_loop_code_and_rx_alarm_status.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_loop_code_and_rx_alarm_status;
  localparam int P = 20;
  logic ref_clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, lu, ld, ao, sl, ps, remote_loopback_reg, irq_reg;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, b;
  logic [2:0]  v, old;
  int          n_fail, checked, seed, i;
  remote_net_end u_far (.ref_clk(ref_clk), .loop_up_det(lu), .loop_down_det(ld),
    .all_ones_det(ao), .signal_lost_det(sl), .prbs_sync_det(ps));
  loop_code_and_rx_alarm_status #(.PERSIST_CYCLES(P)) dut (.ref_clk(ref_clk),
    .reset_n(reset_n), .loop_up_det(lu), .loop_down_det(ld), .all_ones_det(ao),
    .signal_lost_det(sl), .prbs_sync_det(ps), .remote_loopback_reg(remote_loopback_reg),
    .irq_reg(irq_reg), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  function automatic logic [31:0] chg(input logic [2:0] a, input logic [2:0] b);
    return {29'h0, a ^ b};
  endfunction
  task automatic wr(input logic [4:0] a, input logic [7:0] w);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, w};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end
    while (s_axi_bvalid !== 1'b1 && n < 50);
    b = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) begin n_fail++; tally_and_finish; end
  endtask
  task automatic rd(input logic [4:0] a);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end
    while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) begin n_fail++; tally_and_finish; end
  endtask
  initial
  begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    {n_fail, checked, old} = 0;
    seed = 1;
    cyc(20);
    reset_n <= 1'b1;
    for (i = 0; i < 4; i++) begin rd(i * 4); `CHK("reset", 32'h0, d) end
    rd(5'h10); `CHK("resp", 2'h2, r) `CHK("unmapped", 32'h0, d)
    // Random alarm levels; each step is one change so the sticky bits are exact
    for (i = 0; i < 12; i++)
    begin
      v = $random(seed);
      u_far.alarms(v);
      cyc(4);
      rd(5'h04); `CHK("live", {29'h0, v}, d)
      rd(5'h08); `CHK("chg", chg(old, v), d)
      old = v;
    end
    old[0] = ~old[0];
    u_far.alarms(old);
    cyc(4);
    wr(5'h08, 8'h0F); `CHK("w1c resp", 2'h0, b)
    rd(5'h08); `CHK("w1c", 32'h0, d)
    wr(5'h10, 8'hFF); `CHK("wr resp", 2'h2, b)
    wr(5'h04, 8'hFF); `CHK("ro resp", 2'h0, b)
    rd(5'h04); `CHK("ro", {29'h0, old}, d)
    for (i = 0; i < 3; i++)
    begin
      wr(5'h00, 8'h01 << i);
      old[i] = ~old[i];
      u_far.alarms(old);
      cyc(6); `CHK("gated", 1'b0, irq_reg)
      wr(5'h00, 8'h80 | (8'h01 << i));
      cyc(3); `CHK("irq", 1'b1, irq_reg)
      rd(5'h08);
      cyc(3); `CHK("irq clr", 1'b0, irq_reg)
    end
    wr(5'h00, 8'h88);
    wr(5'h0C, 8'h01);
    u_far.codes(1, 0); cyc(12); u_far.codes(0, 0); cyc(3); u_far.codes(1, 0); cyc(12);
    rd(5'h04); `CHK("restart", 1'b0, d[3])
    cyc(P + 8); rd(5'h04); `CHK("man up", 1'b1, d[3])
    `CHK("man irq", 1'b1, irq_reg)
    rd(5'h08); u_far.codes(0, 0); cyc(5);
    rd(5'h04); `CHK("man drop", 1'b0, d[3])
    rd(5'h08); `CHK("man fall", 1'b1, d[3])
    wr(5'h0C, 8'h02); u_far.codes(0, 1); cyc(P + 8);
    rd(5'h04); `CHK("man dn", 1'b1, d[3])
    rd(5'h00); `CHK("en clr", 32'h80, d)
    wr(5'h00, 8'h88); u_far.codes(1, 0); cyc(P + 8);
    wr(5'h0C, 8'h03); rd(5'h04); `CHK("auto entry", 1'b0, d[3])
    cyc(P + 8); `CHK("lb on", 1'b1, remote_loopback_reg)
    rd(5'h04); `CHK("auto flag", 1'b1, d[3])
    u_far.codes(0, 0); cyc(P + 8); `CHK("lb hold", 1'b1, remote_loopback_reg)
    rd(5'h04); `CHK("hold flag", 1'b1, d[3])
    rd(5'h08); u_far.codes(0, 1); cyc(P + 8);
    `CHK("lb off", 1'b0, remote_loopback_reg)
    rd(5'h00); `CHK("auto en clr", 32'h80, d)
    rd(5'h08); `CHK("auto chg", 1'b1, d[3])
    tally_and_finish;
  end
endmodule // tb_loop_code_and_rx_alarm_status
`default_nettype wire
